// File: bench/framer_model.sv
// terminal framer model: line clock and rail data for the sampler
`timescale 1ns/1ps
module framer_model (
  input  wire logic rise_mode,        // launch data for rising-edge sampling
  input  wire logic tip,              // tip output of the sampler
  input  wire logic ring,             // ring output of the sampler
  output logic      tx_sample_clock,  // free-running line clock
  output logic      tx_pos_rail_in,   // positive rail data
  output logic      tx_neg_rail_in    // negative rail data
);
  // ----------------------------------------------------------------
  // line clock
  // ----------------------------------------------------------------
  // 64 ns period; the 7 ns offset keeps it out of phase with pclk
  initial begin
    tx_sample_clock = 1'b0;
    tx_pos_rail_in  = 1'b0;
    tx_neg_rail_in  = 1'b0;
    #7;
    forever #32 tx_sample_clock = ~tx_sample_clock;
  end

  // ----------------------------------------------------------------
  // bit transfer
  // ----------------------------------------------------------------
  // launch on the edge opposite the sampling edge, release right after it,
  // then return tip and ring at the edge where the pulse should stand
  task send(input logic p, input logic n, output logic [1:0] line);
    if (rise_mode) begin
      @(negedge tx_sample_clock);
    end else begin
      @(posedge tx_sample_clock);
    end
    tx_pos_rail_in <= p;
    tx_neg_rail_in <= n;
    @(posedge tx_sample_clock);
    tx_pos_rail_in <= 1'b0;
    tx_neg_rail_in <= 1'b0;
    if (rise_mode) begin
      @(posedge tx_sample_clock);
    end
    #1 line = {tip, ring};
  endtask : send
endmodule : framer_model

// File: bench/testbench.sv
// self-checking bench for the transmit rail input sampler
`timescale 1ns/1ps
module testbench;
  import tx_rail_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;  // apb master side
  logic [7:0]  paddr;                                 // apb address
  logic [31:0] pwdata, prdata, rd;                    // apb data, last read
  logic        pready, pslverr, err;                  // apb answer, last error
  logic        link_clk, pos, neg, tip, ring;         // line side
  logic        rise_mode;                             // model launch edge
  logic [1:0]  line;                                  // tip and ring seen
  logic [2:0]  modes [6] = '{3'h0, 3'h4, 3'h1, 3'h7, 3'h3, 3'h2};  // control words
  int          err_count, checked, cycles;            // counters

  tx_rail_input_sampler uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_sample_clock(link_clk), .tx_pos_rail_in(pos),
    .tx_neg_rail_in(neg), .tx_line_tip_out(tip), .tx_line_ring_out(ring));
  framer_model fm (.rise_mode(rise_mode), .tip(tip), .ring(ring),
    .tx_sample_clock(link_clk), .tx_pos_rail_in(pos), .tx_neg_rail_in(neg));

  // ----------------------------------------------------------------
  // clock and timeout
  // ----------------------------------------------------------------
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  // the whole run needs well under 2000 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // one apb transfer; answer taken at the edge where pready is high
  task apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the bench timeout ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task cmp_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_reg

  task cmp_line(input string what, input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_line

  task results;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rise_mode = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb_xfer(1'b0, CTRL_OFF, 32'h0000_0000);
    cmp_reg("ctrl reset", 32'h0000_0000, rd);
    apb_xfer(1'b0, STATUS_OFF, 32'h0000_0000);
    cmp_reg("status reset", 32'h0000_0000, rd);
    apb_xfer(1'b0, 8'h08, 32'h0000_0000);
    cmp_reg("unmapped error", 32'h0000_0001, {31'h0, err});
    cmp_reg("unmapped data", 32'h0000_0000, rd);
    // six of the eight control words: edge select, rail format, pulse mapping and event flags
    foreach (modes[i]) begin
      apb_xfer(1'b1, CTRL_OFF, {29'h0, modes[i]});
      apb_xfer(1'b0, CTRL_OFF, 32'h0000_0000);
      cmp_reg("ctrl readback", {29'h0, modes[i]}, rd);
      rise_mode = modes[i][CTRL_HOST_BIT] & modes[i][CTRL_RISING_BIT];
      repeat (8) @(posedge pclk);
      fm.send(1'b1, 1'b0, line);
      cmp_line("positive pulse", 2'b10, line);
      fm.send(1'b0, 1'b1, line);
      cmp_line("negative pulse", 2'b01, line);
      fm.send(1'b1, 1'b1, line);
      cmp_line("both rails", 2'b00, line);
      repeat (10) @(posedge pclk);
      apb_xfer(1'b0, STATUS_OFF, 32'h0000_0000);
      cmp_reg("status events", {28'h0, ~modes[i][CTRL_DUAL_BIT], 3'b111}, rd);
      apb_xfer(1'b1, STATUS_OFF, 32'h0000_000f);
      apb_xfer(1'b0, STATUS_OFF, 32'h0000_0000);
      cmp_reg("status cleared", 32'h0000_0000, rd);
    end
    results();
  end
endmodule : testbench

// File: logic/sync_stage.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module sync_stage #(
  parameter int W = 1  // bits carried
) (
  input  wire logic         clk,    // destination clock
  input  wire logic         rst_n,  // async reset, active low
  input  wire logic [W-1:0] d,      // source level
  output logic      [W-1:0] q       // synchronised level
);

  logic [W-1:0] meta;  // first stage, read only by q

  // ----------------------------------------------------------------
  // two stages, constant reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : sync_stage

// File: logic/tx_rail_input_sampler.sv
// transmit rail input sampler with apb control and tip/ring line outputs
// Notes on behaviour
// - rails sampled on falling clock edge by default
// - host mode allows rising or falling sample edge
// - positive-rail one with negative rail zero gives positive line pulse
// - negative-rail one with positive rail zero gives negative line pulse
// - dual rail: negative rail carries negative data
// - tip and ring driven together as pair
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
module tx_rail_input_sampler
  import tx_rail_pkg::*;
#(
  parameter int AW = 8  // apb address width
) (
  input  wire logic          pclk,             // register clock, 20 MHz
  input  wire logic          presetn,          // async reset, active low
  input  wire logic [AW-1:0] paddr,            // apb byte address
  input  wire logic          psel,             // apb select
  input  wire logic          penable,          // apb access phase
  input  wire logic          pwrite,           // apb write
  input  wire logic [31:0]   pwdata,           // apb write data
  output logic      [31:0]   prdata,           // apb read data
  output logic               pready,           // apb ready
  output logic               pslverr,          // apb error, unmapped address
  input  wire logic          tx_sample_clock,  // line-rate transmit clock
  input  wire logic          tx_pos_rail_in,   // positive rail data
  input  wire logic          tx_neg_rail_in,   // negative rail data
  output logic               tx_line_tip_out,  // tip: high for positive pulse
  output logic               tx_line_ring_out  // ring: high for negative pulse
);

  // ----------------------------------------------------------------
  // register bus side
  // ----------------------------------------------------------------
  ctrl_s ctrl;         // control word
  evt_s  status;       // sticky event flags
  evt_s  next_status;  // status after set and clear
  evt_s  evt_tog_p;    // event toggles seen in pclk domain
  evt_s  evt_tog_d;    // previous toggles for edge detect
  evt_s  evt_set;      // one-cycle event pulses

  wire logic [7:0] addr_lo   = paddr[7:0];                  // register offset
  wire logic       hit_ctrl  = (addr_lo == CTRL_OFF);       // control selected
  wire logic       hit_stat  = (addr_lo == STATUS_OFF);     // status selected
  wire logic       hit       = hit_ctrl | hit_stat;         // mapped address
  wire logic       access    = psel & penable & ~pready;    // first access cycle
  wire logic       done      = psel & penable & pready;     // completing edge
  wire logic       wr_ctrl   = done & pwrite & hit_ctrl;    // control write
  wire logic       wr_stat   = done & pwrite & hit_stat;    // status clear
  wire evt_s       clr_mask  = wr_stat ? evt_s'(pwdata[STATUS_W-1:0]) : evt_s'(STATUS_RESET);

  // read mux; bits above the fields read as zero
  wire logic [31:0] rd_data = hit_ctrl ? {29'h0000_0000, ctrl} :
                              hit_stat ? {28'h000_0000, status} : 32'h0000_0000;

  assign evt_set     = evt_tog_p ^ evt_tog_d;
  // a new event wins over a clear in the same cycle
  assign next_status = (status & ~clr_mask) | evt_set;

  // apb answer: one wait cycle, then pready for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & ~hit;
      if (access) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // control and status registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= ctrl_s'(CTRL_RESET);
      status    <= evt_s'(STATUS_RESET);
      evt_tog_d <= evt_s'(STATUS_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl <= ctrl_s'(pwdata[CTRL_W-1:0]);
      end
      status    <= next_status;
      evt_tog_d <= evt_tog_p;
    end
  end

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  logic  link_rst_n;  // link-domain reset, released on link clock
  ctrl_s ctrl_sync;   // control bits after the synchroniser, may be skewed
  ctrl_s ctrl_prev;   // previous synchronised sample
  ctrl_s ctrl_l;      // settled control word in link domain
  evt_s  evt_tog_l;   // event toggles in link domain

  // reset release synchronised to the link clock
  sync_stage #(.W(1)) u_link_rst (
    .clk   (tx_sample_clock),
    .rst_n (presetn),
    .d     (1'b1),
    .q     (link_rst_n)
  );

  // control levels into the link domain
  sync_stage #(.W(CTRL_W)) u_ctrl_sync (
    .clk   (tx_sample_clock),
    .rst_n (link_rst_n),
    .d     (ctrl),
    .q     (ctrl_sync)
  );

  // the bits may land one link edge apart; a word is taken only once two
  // successive samples agree, so a half-written mode is never used
  wire logic ctrl_settled = (ctrl_sync == ctrl_prev);  // no bit in flight

  // settled control word and the sample before it
  always_ff @(posedge tx_sample_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ctrl_prev <= ctrl_s'(CTRL_RESET);
      ctrl_l    <= ctrl_s'(CTRL_RESET);
    end else begin
      ctrl_prev <= ctrl_sync;
      if (ctrl_settled) begin
        ctrl_l <= ctrl_sync;
      end
    end
  end

  // event toggles back into the register domain
  sync_stage #(.W(STATUS_W)) u_evt_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (evt_tog_l),
    .q     (evt_tog_p)
  );

  // ----------------------------------------------------------------
  // link side: sampling
  // ----------------------------------------------------------------
  logic fall_pos;  // positive rail at falling edge
  logic fall_neg;  // negative rail at falling edge
  logic rise_pos;  // positive rail at rising edge
  logic rise_neg;  // negative rail at rising edge

  // rising edge only when host mode allows it, else falling
  wire logic edge_rising = ctrl_l.host_mode & ctrl_l.sample_rising;
  wire logic sel_pos     = edge_rising ? rise_pos : fall_pos;
  wire logic sel_neg     = edge_rising ? rise_neg : fall_neg;
  wire logic pulse_pos   = sel_pos & ~sel_neg;
  wire logic pulse_neg   = sel_neg & ~sel_pos;

  wire evt_s evt_now = '{neg_single: sel_neg & ~ctrl_l.dual_rail,
                         both_rails: sel_pos & sel_neg,
                         neg_seen:   pulse_neg,
                         pos_seen:   pulse_pos};

  // falling-edge capture of both rails
  always_ff @(negedge tx_sample_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fall_pos <= 1'b0;
      fall_neg <= 1'b0;
    end else begin
      fall_pos <= tx_pos_rail_in;
      fall_neg <= tx_neg_rail_in;
    end
  end

  // rising-edge capture of both rails
  always_ff @(posedge tx_sample_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rise_pos <= 1'b0;
      rise_neg <= 1'b0;
    end else begin
      rise_pos <= tx_pos_rail_in;
      rise_neg <= tx_neg_rail_in;
    end
  end

  // ----------------------------------------------------------------
  // link side: line pair and event toggles
  // ----------------------------------------------------------------
  // tip and ring move together; never both high
  always_ff @(posedge tx_sample_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_line_tip_out  <= 1'b0;
      tx_line_ring_out <= 1'b0;
      evt_tog_l        <= evt_s'(STATUS_RESET);
    end else begin
      tx_line_tip_out  <= pulse_pos;
      tx_line_ring_out <= pulse_neg;
      evt_tog_l        <= evt_tog_l ^ evt_now;
    end
  end

  // ----------------------------------------------------------------
  // checks on the link side
  // ----------------------------------------------------------------
  a_default_falling: assert property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n)
    (!ctrl_l.host_mode && fall_pos && !fall_neg) |=> tx_line_tip_out && !tx_line_ring_out)
    else $error("falling-edge positive sample gave no positive pulse");

  a_rising_select: assert property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n)
    (edge_rising && rise_neg && !rise_pos) |=> tx_line_ring_out && !tx_line_tip_out)
    else $error("rising-edge negative sample gave no negative pulse");

  a_rising_ignored: assert property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n)
    (!ctrl_l.host_mode && !fall_pos && !fall_neg) |=> !tx_line_tip_out && !tx_line_ring_out)
    else $error("pulse emitted with no falling-edge sample outside host mode");

  a_pos_pulse: assert property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n)
    (sel_pos && !sel_neg) |=> tx_line_tip_out)
    else $error("positive sample did not drive tip");

  a_neg_pulse: assert property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n)
    (sel_neg && !sel_pos) |=> tx_line_ring_out)
    else $error("negative sample did not drive ring");

  a_dual_neg_data: assert property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n)
    (ctrl_l.dual_rail && sel_neg && !sel_pos) |=> !tx_line_tip_out ##0 tx_line_ring_out)
    else $error("dual-rail negative data lost");

  a_pair_exclusive: assert property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n)
    !(tx_line_tip_out && tx_line_ring_out))
    else $error("tip and ring high together");

  a_both_no_pulse: assert property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n)
    (sel_pos && sel_neg) |=> !tx_line_tip_out && !tx_line_ring_out)
    else $error("pulse emitted with both rails one");

  a_ctrl_settled: assert property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n)
    !$stable(ctrl_l) |-> $past(ctrl_settled))
    else $error("control word taken while still in flight");

  // ----------------------------------------------------------------
  // checks on the register side
  // ----------------------------------------------------------------
  a_apb_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one wait cycle");

  a_event_sticks: assert property (
    @(posedge pclk) disable iff (!presetn)
    (evt_set.pos_seen) |=> status.pos_seen)
    else $error("positive event lost in status");

  a_status_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(status.pos_seen) |-> $past(wr_stat && pwdata[0]))
    else $error("positive event flag cleared without a write");

  a_ctrl_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$stable(ctrl) |-> $past(wr_ctrl))
    else $error("control word changed without a write");

  // bus answer and register contents
  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && !hit) |=> pready && pslverr)
    else $error("unmapped access gave no error");

  a_mapped_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && hit) |=> pready && !pslverr)
    else $error("mapped access gave an error");

  a_read_ctrl: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit_ctrl) |=> prdata == {29'h0000_0000, $past(ctrl)})
    else $error("control read returned wrong data");

  a_write_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite) |=> prdata == 32'h0000_0000)
    else $error("write returned nonzero read data");

  c_pos_pulse: cover property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n) tx_line_tip_out);
  c_neg_pulse: cover property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n) tx_line_ring_out);
  c_rising_mode: cover property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n) edge_rising ##1 tx_line_tip_out);
  c_ctrl_write: cover property (
    @(posedge pclk) disable iff (!presetn) wr_ctrl);
  c_both_rails: cover property (
    @(posedge tx_sample_clock) disable iff (!link_rst_n) sel_pos && sel_neg);

endmodule : tx_rail_input_sampler

// File: logic/tx_rail_pkg.sv
// shared constants and carrier types for the transmit rail input sampler
package tx_rail_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;  // control word
  localparam logic [7:0] STATUS_OFF = 8'h04;  // sticky event flags, write one to clear

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_HOST_BIT   = 0;  // host (serial-configuration) mode
  localparam int CTRL_RISING_BIT = 1;  // sample on rising edge, host mode only
  localparam int CTRL_DUAL_BIT   = 2;  // dual-rail input format
  localparam int CTRL_W          = 3;  // implemented control bits
  localparam int STATUS_W        = 4;  // implemented status bits

  // ----------------------------------------------------------------
  // values after reset and cycle counts
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_RESET   = 3'h0;  // falling edge, single rail
  localparam logic [3:0] STATUS_RESET = 4'h0;  // no events seen
  localparam int         SYNC_STAGES  = 2;     // flops in every crossing
  localparam int         APB_WAIT     = 1;     // wait cycles before pready

  // ----------------------------------------------------------------
  // line rates the far end must supply, in kHz
  // ----------------------------------------------------------------
  localparam int RATE_E3_KHZ  = 34368;  // e3 line clock
  localparam int RATE_DS3_KHZ = 44736;  // ds3 line clock
  localparam int RATE_STS_KHZ = 51840;  // sts-1 line clock

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dual_rail;      // dual-rail input format
    logic sample_rising;  // rising edge select
    logic host_mode;      // host mode enable
  } ctrl_s;

  typedef struct packed {
    logic neg_single;  // negative rail one while in single-rail format
    logic both_rails;  // both rails one in the same bit period
    logic neg_seen;    // negative pulse emitted
    logic pos_seen;    // positive pulse emitted
  } evt_s;

endpackage : tx_rail_pkg
